// ---- hdl/ddr_host_pkg.sv ----
package ddr_host_pkg;

    // ==========================================================
    // Widths
    localparam int NUM_BANKS = 4;
    localparam int ADDR_W    = 13;
    localparam int BANK_W    = 2;
    localparam int TIMER_W   = 8;
    localparam int AP_BIT    = 10;

    // ==========================================================
    // Timing, figures in ns except DLL_LOCK_CYC (cycles) and BURST_LEN (beats), cycle counts derived
    localparam int CLK_PERIOD_NS              = 10;
    localparam int PRECHARGE_WAIT_NS          = 15;
    localparam int ACTIVATE_TO_ACCESS_WAIT_NS = 15;
    localparam int REFRESH_CYCLE_WAIT_NS      = 70;
    localparam int MODE_LOAD_WAIT_NS          = 10;
    localparam int SELF_REFRESH_EXIT_WAIT_NS  = 75;
    localparam int WRITE_RECOVERY_NS          = 15;
    localparam int DLL_LOCK_CYC               = 200;
    localparam int BURST_LEN                  = 4;

    localparam int PRECHARGE_WAIT_CYC =
        (PRECHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACTIVATE_TO_ACCESS_WAIT_CYC =
        (ACTIVATE_TO_ACCESS_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_CYCLE_WAIT_CYC =
        (REFRESH_CYCLE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_LOAD_WAIT_CYC =
        (MODE_LOAD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELF_REFRESH_EXIT_WAIT_CYC =
        (SELF_REFRESH_EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVERY_CYC =
        (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_CYC = BURST_LEN / 2;

    // Timers load count-1 and expire on zero; DLL_LOAD and MASK_LOAD load the full count
    localparam logic [TIMER_W-1:0] RP_LOAD    = TIMER_W'(PRECHARGE_WAIT_CYC - 1);
    localparam logic [TIMER_W-1:0] RCD_LOAD   = TIMER_W'(ACTIVATE_TO_ACCESS_WAIT_CYC - 1);
    localparam logic [TIMER_W-1:0] RFC_LOAD   = TIMER_W'(REFRESH_CYCLE_WAIT_CYC - 1);
    localparam logic [TIMER_W-1:0] MRD_LOAD   = TIMER_W'(MODE_LOAD_WAIT_CYC - 1);
    localparam logic [TIMER_W-1:0] XSNR_LOAD  = TIMER_W'(SELF_REFRESH_EXIT_WAIT_CYC - 1);
    localparam logic [TIMER_W-1:0] DLL_LOAD   = TIMER_W'(DLL_LOCK_CYC);
    localparam logic [TIMER_W-1:0] RD_LOAD    = TIMER_W'(BURST_CYC - 1);
    localparam logic [TIMER_W-1:0] WR_LOAD    = TIMER_W'(BURST_CYC - 1);
    localparam logic [TIMER_W-1:0] WR_AP_LOAD =
        TIMER_W'(BURST_CYC + WRITE_RECOVERY_CYC - 1);
    localparam logic [3:0]         MASK_LOAD  = 4'(BURST_CYC);

    // ==========================================================
    // Pin codes: select, row, column, write strobes (active low)
    localparam logic [3:0] CMD_DESELECT   = 4'hF;
    localparam logic [3:0] CMD_NOP        = 4'h7;
    localparam logic [3:0] CMD_ACTIVATE   = 4'h3;
    localparam logic [3:0] CMD_REFRESH    = 4'h1;
    localparam logic [3:0] CMD_MODE_LOAD  = 4'h0;
    localparam logic [3:0] CMD_READ       = 4'h5;
    localparam logic [3:0] CMD_WRITE      = 4'h4;
    localparam logic [3:0] CMD_PRECHARGE  = 4'h2;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        OP_ACTIVATE, OP_READ, OP_WRITE, OP_PRECHARGE, OP_PRECHARGE_ALL,
        OP_REFRESH, OP_MODE_LOAD, OP_BURST_STOP, OP_POWER_DOWN, OP_SELF_REFRESH
    } host_op_t;

    typedef struct packed {
        host_op_t          op;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic              auto_pre;
    } host_req_t;

    typedef struct packed {
        logic              cke;
        logic [3:0]        cmd;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] addr;
        logic              write_byte_mask;
    } pins_t;

    localparam pins_t PINS_RESET = '{cke: 1'b1, cmd: CMD_NOP, default: '0};

    typedef enum logic [2:0] {
        B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING,
        B_READ_AP, B_WRITE_AP, B_PRECHARGING
    } bank_state_t;

    typedef struct packed {
        bank_state_t        st;
        logic [TIMER_W-1:0] timer;
    } bank_reg_t;

    typedef enum logic [2:0] {
        M_RUN, M_BUSY, M_PD, M_PD_EXIT, M_SR, M_SR_EXIT
    } mode_t;

    typedef struct packed {
        mode_t              mode;
        pins_t              pins;
        logic               ack;
        logic               pd_flag;
        logic               sr_flag;
        logic [TIMER_W-1:0] gtimer;
        logic [TIMER_W-1:0] read_block;
        logic [3:0]         mask_cnt;
        logic [BANK_W-1:0]  last_read;
    } host_reg_t;

endpackage : ddr_host_pkg

// ---- hdl/bank_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none

module bank_tracker
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 issue,
    input  wire ddr_host_pkg::host_op_t op,
    input  wire logic                 auto_pre,
    output ddr_host_pkg::bank_state_t state
);
    import ddr_host_pkg::*;

    bank_reg_t r_reg;
    bank_reg_t r_next;

    assign state = r_reg.st;

    always_comb
    begin
        r_next = r_reg;
        if (r_reg.timer != '0)
            r_next.timer = r_reg.timer - 1'b1;
        unique case (r_reg.st)
            B_IDLE:
                if (issue && op == OP_ACTIVATE)
                begin
                    r_next.st    = B_ACTIVATING;
                    r_next.timer = RCD_LOAD;
                end
            B_ACTIVATING:
                if (r_reg.timer == '0)
                    r_next.st = B_ACTIVE;
            B_ACTIVE, B_READING, B_WRITING:
            begin
                if (r_reg.st != B_ACTIVE && r_reg.timer == '0)
                    r_next.st = B_ACTIVE;
                if (issue)
                begin
                    if (op == OP_READ)
                    begin
                        r_next.st    = auto_pre ? B_READ_AP : B_READING;
                        r_next.timer = RD_LOAD;
                    end
                    else if (op == OP_WRITE)
                    begin
                        r_next.st    = auto_pre ? B_WRITE_AP : B_WRITING;
                        r_next.timer = auto_pre ? WR_AP_LOAD : WR_LOAD;
                    end
                    else if (op == OP_PRECHARGE || op == OP_PRECHARGE_ALL)
                    begin
                        r_next.st    = B_PRECHARGING;
                        r_next.timer = RP_LOAD;
                    end
                    else if (op == OP_BURST_STOP && r_reg.st == B_READING)
                        r_next.st = B_ACTIVE;
                end
            end
            B_READ_AP, B_WRITE_AP:
                if (r_reg.timer == '0)
                begin
                    r_next.st    = B_PRECHARGING;
                    r_next.timer = RP_LOAD;
                end
            B_PRECHARGING:
                if (r_reg.timer == '0)
                    r_next.st = B_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            r_reg <= '{st: B_IDLE, timer: '0};
        else
            r_reg <= r_next;
    end

endmodule : bank_tracker

`default_nettype wire

// ---- hdl/ddr_host_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module ddr_host_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  req_valid,
    input  wire ddr_host_pkg::host_req_t req,
    input  wire logic                  wake,
    input  wire logic                  dll_off,
    output logic                       req_ack,
    output logic                       in_power_down,
    output logic                       in_self_refresh,
    output ddr_host_pkg::pins_t        pins
);
    import ddr_host_pkg::*;

    host_reg_t                    r_reg;
    host_reg_t                    r_next;
    bank_state_t [NUM_BANKS-1:0]  bank_st;
    logic        [NUM_BANKS-1:0]  bank_issue;
    logic                         accept;
    logic                         any_writing;

    assign req_ack         = r_reg.ack;
    assign in_power_down   = r_reg.pd_flag;
    assign in_self_refresh = r_reg.sr_flag;
    assign pins            = r_reg.pins;

    // ==========================================================
    // Legality of a request against bank and global state
    function automatic logic precharge_ok(input bank_state_t s);
        precharge_ok = (s == B_IDLE) || (s == B_ACTIVE) ||
                       (s == B_READING) || (s == B_WRITING);
    endfunction : precharge_ok

    function automatic logic legal
    (
        input host_req_t                   q,
        input bank_state_t [NUM_BANKS-1:0] s,
        input logic [BANK_W-1:0]           lr,
        input logic                        rd_blocked
    );
        logic all_idle;
        logic all_pre_ok;
        logic quiet;
        bank_state_t b;
        all_idle   = 1'b1;
        all_pre_ok = 1'b1;
        quiet      = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            all_idle   = all_idle && (s[i] == B_IDLE);
            all_pre_ok = all_pre_ok && precharge_ok(s[i]);
            quiet      = quiet && (s[i] == B_IDLE || s[i] == B_ACTIVE);
        end
        b = s[q.bank];
        unique case (q.op)
            OP_ACTIVATE:      legal = (b == B_IDLE);
            OP_READ:          legal = !rd_blocked &&
                                      (b == B_ACTIVE || b == B_READING ||
                                       b == B_WRITING);
            OP_WRITE:         legal = (b == B_ACTIVE || b == B_WRITING);
            OP_PRECHARGE:     legal = precharge_ok(b);
            OP_PRECHARGE_ALL: legal = all_pre_ok;
            OP_REFRESH:       legal = all_idle;
            OP_MODE_LOAD:     legal = all_idle;
            OP_BURST_STOP:    legal = (s[lr] == B_READING);
            OP_POWER_DOWN:    legal = quiet;
            OP_SELF_REFRESH:  legal = all_idle;
            default:          legal = 1'b0;
        endcase
    endfunction : legal

    // ==========================================================
    // Bank trackers
    generate
        for (genvar g = 0; g < NUM_BANKS; g++)
        begin : g_bank
            bank_tracker u_bank
            (
                .clk      (clk),
                .reset    (reset),
                .issue    (bank_issue[g]),
                .op       (req.op),
                .auto_pre (req.auto_pre),
                .state    (bank_st[g])
            );
        end
    endgenerate

    // Only run mode takes requests; one blocked cycle after each ack
    assign accept = req_valid && !r_reg.ack && r_reg.mode == M_RUN &&
                    legal(req, bank_st, r_reg.last_read, r_reg.read_block != '0);

    always_comb
    begin
        any_writing = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            any_writing = any_writing || (bank_st[i] == B_WRITING);
            if (req.op == OP_PRECHARGE_ALL)
                bank_issue[i] = accept;
            else if (req.op == OP_BURST_STOP)
                bank_issue[i] = accept && (r_reg.last_read == BANK_W'(i));
            else
                bank_issue[i] = accept && (req.bank == BANK_W'(i));
        end
    end

    // ==========================================================
    // Command sequencer
    always_comb
    begin
        r_next          = r_reg;
        r_next.ack      = accept;
        r_next.pins.cmd = CMD_NOP;
        if (r_reg.gtimer != '0)
            r_next.gtimer = r_reg.gtimer - 1'b1;
        if (r_reg.read_block != '0)
            r_next.read_block = r_reg.read_block - 1'b1;
        if (r_reg.mask_cnt != '0)
            r_next.mask_cnt = r_reg.mask_cnt - 1'b1;
        unique case (r_reg.mode)
            M_RUN:
                if (accept)
                begin
                    r_next.pins.bank_select = req.bank;
                    r_next.pins.addr        = req.addr;
                    unique case (req.op)
                        OP_ACTIVATE:
                            r_next.pins.cmd = CMD_ACTIVATE;
                        OP_READ:
                        begin
                            r_next.pins.cmd          = CMD_READ;
                            r_next.pins.addr[AP_BIT] = req.auto_pre;
                            r_next.last_read         = req.bank;
                            if (bank_st[req.bank] == B_WRITING)
                                r_next.mask_cnt = MASK_LOAD;
                        end
                        OP_WRITE:
                        begin
                            r_next.pins.cmd          = CMD_WRITE;
                            r_next.pins.addr[AP_BIT] = req.auto_pre;
                        end
                        OP_PRECHARGE:
                        begin
                            r_next.pins.cmd          = CMD_PRECHARGE;
                            r_next.pins.addr[AP_BIT] = 1'b0;
                            if (bank_st[req.bank] == B_WRITING)
                                r_next.mask_cnt = MASK_LOAD;
                        end
                        OP_PRECHARGE_ALL:
                        begin
                            r_next.pins.cmd          = CMD_PRECHARGE;
                            r_next.pins.addr[AP_BIT] = 1'b1;
                            r_next.mode              = M_BUSY;
                            r_next.gtimer            = RP_LOAD;
                            if (any_writing)
                                r_next.mask_cnt = MASK_LOAD;
                        end
                        OP_REFRESH:
                        begin
                            r_next.pins.cmd = CMD_REFRESH;
                            r_next.mode     = M_BUSY;
                            r_next.gtimer   = RFC_LOAD;
                        end
                        OP_MODE_LOAD:
                        begin
                            r_next.pins.cmd = CMD_MODE_LOAD;
                            r_next.mode     = M_BUSY;
                            r_next.gtimer   = MRD_LOAD;
                        end
                        OP_BURST_STOP:
                            r_next.pins.cmd = CMD_BURST_STOP;
                        OP_POWER_DOWN:
                        begin
                            r_next.pins.cke = 1'b0;
                            r_next.pd_flag  = 1'b1;
                            r_next.mode     = M_PD;
                        end
                        OP_SELF_REFRESH:
                        begin
                            r_next.pins.cmd = CMD_REFRESH;
                            r_next.pins.cke = 1'b0;
                            r_next.sr_flag  = 1'b1;
                            r_next.mode     = M_SR;
                        end
                    endcase
                end
            M_BUSY:
                if (r_reg.gtimer == '0)
                    r_next.mode = M_RUN;
            M_PD:
                if (wake)
                begin
                    r_next.pins.cke = 1'b1;
                    r_next.mode     = M_PD_EXIT;
                    if (dll_off)
                        r_next.read_block = DLL_LOAD;
                end
            M_PD_EXIT:
            begin
                r_next.pd_flag = 1'b0;
                r_next.mode    = M_RUN;
            end
            M_SR:
                if (wake)
                begin
                    r_next.pins.cke   = 1'b1;
                    r_next.mode       = M_SR_EXIT;
                    r_next.gtimer     = XSNR_LOAD;
                    r_next.read_block = DLL_LOAD;
                end
            M_SR_EXIT:
                if (r_reg.gtimer == '0)
                begin
                    r_next.sr_flag = 1'b0;
                    r_next.mode    = M_RUN;
                end
        endcase
        r_next.pins.write_byte_mask = (r_next.mask_cnt != '0);
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            r_reg      <= '0;
            r_reg.mode <= M_RUN;
            r_reg.pins <= PINS_RESET;
        end
        else
            r_reg <= r_next;
    end

endmodule : ddr_host_ctrl

`default_nettype wire

// ---- tb/ddr_host_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr_host_props
(
    input wire logic                    clk,
    input wire logic                    reset,
    input wire logic                    req_valid,
    input wire ddr_host_pkg::host_req_t req,
    input wire logic                    wake,
    input wire logic                    dll_off,
    input wire logic                    req_ack,
    input wire logic                    in_power_down,
    input wire logic                    in_self_refresh,
    input wire ddr_host_pkg::pins_t     pins
);
    import ddr_host_pkg::*;
    logic idle_cmd;
    assign idle_cmd = pins.cmd == CMD_NOP;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // ==========
    // Exit steps
    sequence s_wake_exit;
        !pins.cke && wake ##1 pins.cke && idle_cmd;
    endsequence
    sequence s_quiet7;
        idle_cmd [*7];
    endsequence
    a_ack_single: assert property (req_ack |=> !req_ack) else $error("ack too long");
    a_cmd_needs_ack: assert property (pins.cke && !idle_cmd && pins.cmd != CMD_DESELECT |-> req_ack)
        else $error("command without ack");
    a_cmd_one_cycle: assert property (req_ack |=> idle_cmd) else $error("command held");
    a_entry_flags: assert property ($fell(pins.cke) |-> in_power_down || in_self_refresh)
        else $error("clock-keep low without flag");
    a_hold_low: assert property (!pins.cke && !wake |=> !pins.cke) else $error("left sleep");
    a_wake_exit: assert property (!pins.cke && wake |=> pins.cke && idle_cmd)
        else $error("bad exit");
    a_pd_release: assert property (s_wake_exit ##0 in_power_down |=> !in_power_down)
        else $error("power-down flag stuck");
    a_sr_quiet: assert property ($rose(pins.cke) && in_self_refresh |=> s_quiet7)
        else $error("command in exit wait");
    a_mode_exclusive: assert property (!(in_power_down && in_self_refresh))
        else $error("both sleep flags");
    a_refresh_quiet: assert property (pins.cke && pins.cmd == CMD_REFRESH |=> idle_cmd [*6])
        else $error("command during refresh");
    a_pre_all_quiet: assert property (pins.cmd == CMD_PRECHARGE && pins.addr[AP_BIT] |=>
        idle_cmd [*2]) else $error("command during precharge-all");
endmodule : ddr_host_props
bind ddr_host_ctrl ddr_host_props u_props (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req(req), .wake(wake), .dll_off(dll_off), .req_ack(req_ack), .pins(pins),
    .in_power_down(in_power_down), .in_self_refresh(in_self_refresh));
`default_nettype wire

// ---- tb/ddr_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr_device_model
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire ddr_host_pkg::pins_t pins,
    output logic [3:0]               open_rows,
    output logic                     dozing,
    output int                       bad_cnt
);
    import ddr_host_pkg::*;
    logic       cke_reg;
    logic       sr_reg;
    int         exit_cnt;
    logic [3:0] sel;
    assign sel = 4'h1 << pins.bank_select;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cke_reg   <= 1'b1;
            sr_reg    <= 1'b0;
            open_rows <= 4'h0;
            dozing    <= 1'b0;
            bad_cnt   <= 0;
            exit_cnt  <= 1000;
        end
        else
        begin
            cke_reg  <= pins.cke;
            exit_cnt <= exit_cnt + 1;
            if (cke_reg && !pins.cke)
            begin
                dozing <= 1'b1;
                sr_reg <= pins.cmd == CMD_REFRESH;
            end
            else if (!cke_reg && pins.cke)
            begin
                dozing  <= 1'b0;
                bad_cnt <= bad_cnt + int'(pins.cmd != CMD_NOP);
                if (sr_reg)
                    exit_cnt <= 0;
            end
            else if (pins.cke)
                case (pins.cmd)
                    CMD_ACTIVATE:
                        open_rows <= open_rows | sel;
                    CMD_READ, CMD_WRITE:
                    begin
                        bad_cnt <= bad_cnt + int'(!(|(open_rows & sel)) ||
                            (pins.cmd == CMD_READ && exit_cnt < DLL_LOCK_CYC - 1));
                        if (pins.addr[AP_BIT])
                            open_rows <= open_rows & ~sel;
                    end
                    CMD_PRECHARGE:
                        open_rows <= pins.addr[AP_BIT] ? 4'h0 : open_rows & ~sel;
                    CMD_REFRESH, CMD_MODE_LOAD:
                        bad_cnt <= bad_cnt + int'(open_rows != 4'h0);
                    default: ;
                endcase
        end
    end
endmodule : ddr_device_model
`default_nettype wire

// ---- tb/ddr_bank_cmd_state_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr_bank_cmd_state_logic_tb_top;
    import ddr_host_pkg::*;
    logic       clk = 1'b0;
    logic       reset, req_valid, wake, dll_off, req_ack, in_power_down, in_self_refresh, dozing;
    host_req_t  req;
    pins_t      pins;
    logic [3:0] open_rows;
    int         bad_cnt, w;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cycles = 0;
    always #5 clk = ~clk;
    ddr_host_ctrl dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req), .wake(wake),
        .dll_off(dll_off), .req_ack(req_ack), .in_power_down(in_power_down),
        .in_self_refresh(in_self_refresh), .pins(pins));
    ddr_device_model partner (.clk(clk), .reset(reset), .pins(pins), .open_rows(open_rows),
        .dozing(dozing), .bad_cnt(bad_cnt));
    // ==========
    // Helpers
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic issue(input host_op_t op, input logic [1:0] b, input logic ap,
                         input logic [3:0] cmd);
        req = '{op: op, bank: b, addr: 13'h0123, auto_pre: ap};
        req_valid = 1'b1;
        w = 0;
        while (req_ack !== 1'b1 && w < 400)
        begin
            tick(1);
            w++;
        end
        check(24'(w < 400), 24'h1);
        check(24'(pins.cmd), 24'(cmd));
        check(24'(pins.addr[AP_BIT]), 24'(op == OP_PRECHARGE_ALL || ap));
        if (op inside {OP_ACTIVATE, OP_READ, OP_WRITE, OP_PRECHARGE})
            check(24'(pins.bank_select), 24'(b));
        req_valid = 1'b0;
        tick(1);
    endtask : issue
    task automatic finish_test;
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // ==========
    // Scenarios
    task automatic t_rows;
        for (int b = 0; b < NUM_BANKS; b++)
            issue(OP_ACTIVATE, 2'(b), 1'b0, CMD_ACTIVATE);
        check(24'(open_rows), 24'hF);
        check(24'(pins.write_byte_mask), 24'h0);
        issue(OP_READ, 2'h1, 1'b0, CMD_READ);
        issue(OP_BURST_STOP, 2'h0, 1'b0, CMD_BURST_STOP);
        issue(OP_WRITE, 2'h1, 1'b0, CMD_WRITE);
        issue(OP_PRECHARGE, 2'h1, 1'b0, CMD_PRECHARGE);
        check(24'(pins.write_byte_mask), 24'h1);
        check(24'(open_rows), 24'hD);
        issue(OP_READ, 2'h2, 1'b1, CMD_READ);
        check(24'(open_rows), 24'h9);
        check(24'(pins.write_byte_mask), 24'h0);
        issue(OP_ACTIVATE, 2'h2, 1'b0, CMD_ACTIVATE);
        issue(OP_PRECHARGE_ALL, 2'h2, 1'b0, CMD_PRECHARGE);
        check(24'(open_rows), 24'h0);
        issue(OP_REFRESH, 2'h0, 1'b0, CMD_REFRESH);
        issue(OP_MODE_LOAD, 2'h0, 1'b0, CMD_MODE_LOAD);
    endtask : t_rows
    task automatic t_power(input logic off);
        dll_off = off;
        issue(OP_ACTIVATE, 2'h0, 1'b0, CMD_ACTIVATE);
        issue(OP_POWER_DOWN, 2'h0, 1'b0, CMD_NOP);
        check({pins.cke, in_power_down, dozing}, 24'h3);
        tick(5);
        check(24'(pins.cke), 24'h0);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        check({pins.cke, pins.cmd}, {1'b1, CMD_NOP});
        tick(1);
        check(24'(in_power_down), 24'h0);
        issue(OP_READ, 2'h0, 1'b0, CMD_READ);
        check(24'(w > 190), 24'(off));
        issue(OP_PRECHARGE, 2'h0, 1'b0, CMD_PRECHARGE);
    endtask : t_power
    task automatic t_self_refresh;
        int n;
        int start;
        issue(OP_SELF_REFRESH, 2'h0, 1'b0, CMD_REFRESH);
        check({pins.cke, in_self_refresh, dozing}, 24'h3);
        tick(3);
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        start = cycles;
        check(24'(pins.cke), 24'h1);
        n = 0;
        while (in_self_refresh === 1'b1 && n < 50)
        begin
            tick(1);
            n++;
        end
        check(24'(n), 24'(SELF_REFRESH_EXIT_WAIT_CYC));
        issue(OP_ACTIVATE, 2'h1, 1'b0, CMD_ACTIVATE);
        issue(OP_READ, 2'h1, 1'b0, CMD_READ);
        check(24'(cycles - 1 - start >= DLL_LOCK_CYC), 24'h1);
        issue(OP_PRECHARGE, 2'h1, 1'b0, CMD_PRECHARGE);
    endtask : t_self_refresh
    initial
    begin
        reset = 1'b1;
        req_valid = 1'b0;
        wake = 1'b0;
        dll_off = 1'b0;
        req = '0;
        tick(6);
        reset = 1'b0;
        tick(1);
        check({req_ack, in_power_down, in_self_refresh, pins}, 24'(PINS_RESET));
        t_rows;
        t_power(1'b0);
        t_power(1'b1);
        t_self_refresh;
        check(24'(bad_cnt), 24'h0);
        finish_test;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            finish_test;
        end
    end
endmodule : ddr_bank_cmd_state_logic_tb_top
`default_nettype wire
